// >>> ppc_top.sv
// Overview of operation
// - Ten 8-bit drive registers at indexes 0x00 to 0x09 each set one pin.
// - Code 0x00 drives the pin low, input buffer on, reads 0, kept in shutdown.
// - Code 0x01 leaves the pin high impedance as a logic input, kept in shutdown.
// - Code 0x02 sinks current continuously, input off, off in shutdown.
// - Codes 0x03 to 0xfe sink current with duty code/256, off in shutdown.
// - Code 0xff leaves the pin high impedance with sink and input off.
// - The low levels register returns pins 7 to 0 in bits 7 to 0.
// - The high levels register returns pins 9 and 8 in bits 1 and 0, rest zero.
// - A pin not set as logic input reads as zero in the levels registers.
// - Writes to the levels registers are ignored.
// - The PWM time base is the internal oscillator or the external clock pin.
// - The reset clock source depends on the device variant.
// - Group addresses write several drive registers; reads give the lowest.
//
// Decided for this implementation: the APB slave port.
module ppc_top
  import ppc_pkg::*;
#(
  parameter logic VARIANT_EXT_CLK = 1'b0
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            ce,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ppc_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [ppc_pkg::DATA_W-1:0]      pwdata,
  output logic      [ppc_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            internal_osc_in,
  input  wire logic                            serial_out_or_pwm_clock_pin_in,
  input  wire logic [ppc_pkg::NUM_PORTS-1:0]   port_pin_in,
  output logic      [ppc_pkg::NUM_PORTS-1:0]   port_pin_out,
  output logic      [ppc_pkg::NUM_PORTS-1:0]   port_pin_oe,
  output logic      [ppc_pkg::NUM_PORTS-1:0]   port_sink_en,
  output logic      [ppc_pkg::NUM_PORTS-1:0]   general_input_buffer_en
);

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic             mapped;
  logic             setup_ph;
  logic             wr_acc;

  assign idx      = paddr[ADDR_W-1:2];
  assign mapped   = (paddr[1:0] == 2'h0) && (idx <= IDX_PWM_CONFIG);
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // Drive registers
  // ---------------------------------------------------------------
  logic [NUM_PORTS-1:0][CODE_W-1:0] drive_reg;
  logic [NUM_PORTS-1:0]             wr_sel;

  always_comb begin
    wr_sel = '0;
    if (wr_acc) begin
      unique case (idx)
        IDX_GROUP_ALL: wr_sel = 10'h3ff;
        IDX_GROUP_0_3: wr_sel = 10'h00f;
        IDX_GROUP_4_7: wr_sel = 10'h0f0;
        IDX_GROUP_8_9: wr_sel = 10'h300;
        default: begin
          if (idx <= IDX_PORT_DRIVE_9) begin
            wr_sel[idx[3:0]] = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg <= {NUM_PORTS{PORT_DRIVE_RESET}};
    end else if (ce) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (wr_sel[i]) begin
          drive_reg[i] <= pwdata[CODE_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  logic run_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= CFG_RUN_RESET;
    end else if (ce && wr_acc && idx == IDX_PWM_CONFIG) begin
      run_reg <= pwdata[CFG_RUN_BIT];
    end
  end

  // Variant strap taken once after reset release
  logic strap_done_reg;
  logic clk_src_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_reg <= 1'b0;
    end else if (ce) begin
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src_reg <= 1'b0;
    end else if (ce) begin
      if (!strap_done_reg) begin
        clk_src_reg <= VARIANT_EXT_CLK;
      end else if (wr_acc && idx == IDX_PWM_CONFIG) begin
        clk_src_reg <= pwdata[CFG_CLK_SEL_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin level synchroniser and masking
  // ---------------------------------------------------------------
  logic [NUM_PORTS-1:0] pin_s1_reg;
  logic [NUM_PORTS-1:0] pin_s2_reg;
  logic [NUM_PORTS-1:0] levels;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else if (ce) begin
      pin_s1_reg <= port_pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      levels[i] = (drive_reg[i] == CODE_LOGIC_INPUT) && pin_s2_reg[i];
    end
  end

  // ---------------------------------------------------------------
  // Read data, loaded in the setup phase
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rd_next;

  always_comb begin
    rd_next = '0;
    unique case (idx)
      IDX_GROUP_ALL:       rd_next[7:0] = drive_reg[0];
      IDX_GROUP_0_3:       rd_next[7:0] = drive_reg[0];
      IDX_GROUP_4_7:       rd_next[7:0] = drive_reg[4];
      IDX_GROUP_8_9:       rd_next[7:0] = drive_reg[8];
      IDX_PIN_LEVELS_LOW:  rd_next[7:0] = levels[7:0];
      IDX_PIN_LEVELS_HIGH: rd_next[1:0] = levels[9:8];
      IDX_PWM_CONFIG: begin
        rd_next[CFG_CLK_SEL_BIT] = clk_src_reg;
        rd_next[CFG_RUN_BIT]     = run_reg;
      end
      default: begin
        if (idx <= IDX_PORT_DRIVE_9) begin
          rd_next[7:0] = drive_reg[idx[3:0]];
        end
      end
    endcase
    if (!mapped) begin
      rd_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && setup_ph && !pwrite) begin
      prdata <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // PWM time base
  // ---------------------------------------------------------------
  logic [1:0]           osc_s1_reg;
  logic [1:0]           osc_s2_reg;
  logic                 tb_prev_reg;
  logic                 tb_level;
  logic                 tb_tick;
  logic [PWM_CNT_W-1:0] pwm_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_reg <= '0;
      osc_s2_reg <= '0;
    end else if (ce) begin
      osc_s1_reg <= {serial_out_or_pwm_clock_pin_in, internal_osc_in};
      osc_s2_reg <= osc_s1_reg;
    end
  end

  assign tb_level = clk_src_reg ? osc_s2_reg[1] : osc_s2_reg[0];
  assign tb_tick  = tb_level && !tb_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_prev_reg <= 1'b0;
    end else if (ce) begin
      tb_prev_reg <= tb_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_reg <= '0;
    end else if (ce && tb_tick) begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic [NUM_PORTS-1:0] sink_next;
  logic [NUM_PORTS-1:0] oe_next;
  logic [NUM_PORTS-1:0] ibuf_next;

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      oe_next[i]   = (drive_reg[i] == CODE_LOGIC_LOW);
      ibuf_next[i] = (drive_reg[i] == CODE_LOGIC_LOW) ||
                     (drive_reg[i] == CODE_LOGIC_INPUT);
      sink_next[i] = 1'b0;
      if (run_reg) begin
        if (drive_reg[i] == CODE_SINK_STATIC) begin
          sink_next[i] = 1'b1;
        end else if (drive_reg[i] >= CODE_PWM_FIRST &&
                     drive_reg[i] <= CODE_PWM_LAST) begin
          sink_next[i] = (pwm_cnt_reg < drive_reg[i]);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_oe             <= '0;
      port_sink_en            <= '0;
      general_input_buffer_en <= '0;
      port_pin_out            <= '0;
    end else if (ce) begin
      port_pin_oe             <= oe_next;
      port_sink_en            <= sink_next;
      general_input_buffer_en <= ibuf_next;
      port_pin_out            <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_low_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && drive_reg[0] == 8'h00 |=> port_pin_oe[0] && !port_sink_en[0]
      && general_input_buffer_en[0])
    else $error("code 0x00 did not drive pin low");

  a_input_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    ce && drive_reg[1] == 8'h01 |=> !port_pin_oe[1] && !port_sink_en[1]
      && general_input_buffer_en[1])
    else $error("code 0x01 is not a logic input");

  a_sink_static: assert property (@(posedge pclk) disable iff (!presetn)
    ce && run_reg && drive_reg[2] == 8'h02 |=> port_sink_en[2]
      && !general_input_buffer_en[2])
    else $error("code 0x02 did not sink");

  a_sink_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !run_reg |=> port_sink_en == '0)
    else $error("sink active in shutdown");

  a_hiz_code: assert property (@(posedge pclk) disable iff (!presetn)
    ce && drive_reg[3] == 8'hff |=> !port_sink_en[3] && !port_pin_oe[3]
      && !general_input_buffer_en[3])
    else $error("code 0xff not high impedance");

  a_pwm_duty: assert property (@(posedge pclk) disable iff (!presetn)
    ce && run_reg && drive_reg[4] >= 8'h03 && drive_reg[4] <= 8'hfe
      |=> port_sink_en[4] == ($past(pwm_cnt_reg) < $past(drive_reg[4])))
    else $error("PWM sink does not follow duty");

  a_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && paddr == 8'h3c |=> prdata[31:2] == '0
      && prdata[1:0] == $past(levels[9:8]))
    else $error("high levels read wrong");

  a_level_mask: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && paddr == 8'h38 && drive_reg[0] != 8'h01
      |=> prdata[0] == 1'b0)
    else $error("non-input pin read as one");

  a_ro_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr[7:3] == 5'h07 |=> $stable(drive_reg)
      && $stable(run_reg))
    else $error("write to levels register changed state");

  a_group_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && pwrite && paddr == 8'h34
      |=> drive_reg[8] == $past(pwdata[7:0])
      && drive_reg[9] == $past(pwdata[7:0]) && $stable(drive_reg[7]))
    else $error("group write to pins 8-9 failed");

  a_level_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 ce |=> pin_s2_reg == $past(port_pin_in, 2))
    else $error("pin level not two stages late");

  a_port_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && pwrite && paddr == 8'h14
      |=> drive_reg[5] == $past(pwdata[7:0]))
    else $error("single port write lost");

  a_bad_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && pwrite && paddr[1:0] != 2'h0
      |=> $stable(drive_reg) && $stable(run_reg))
    else $error("misaligned write changed state");

  a_oe_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !run_reg && drive_reg[1] == 8'h00
      |=> port_pin_oe[1] && !port_sink_en[1])
    else $error("low drive lost in shutdown");

  a_pwm_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && drive_reg[5] >= 8'h03 && drive_reg[5] <= 8'hfe
      |=> !general_input_buffer_en[5] && !port_pin_oe[5])
    else $error("PWM code left input or low drive on");

  a_low_levels: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && paddr == 8'h38
      |=> prdata == {24'h0, $past(levels[7:0])})
    else $error("low levels read wrong");

  a_int_tick: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !clk_src_reg && osc_s2_reg[0] && !tb_prev_reg
      |=> pwm_cnt_reg == $past(pwm_cnt_reg) + 8'h01)
    else $error("internal time base edge not counted");

  a_ext_tick: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clk_src_reg && osc_s2_reg[1] && !tb_prev_reg
      |=> pwm_cnt_reg == $past(pwm_cnt_reg) + 8'h01)
    else $error("external time base edge not counted");

  a_clk_strap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done_reg) |-> clk_src_reg == VARIANT_EXT_CLK)
    else $error("reset clock source not taken from variant");

  a_group_all: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && penable && pwrite && paddr == 8'h28
      |=> drive_reg[0] == $past(pwdata[7:0]) && drive_reg[9] == drive_reg[0])
    else $error("group write to all pins failed");

  a_group_read: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup_ph && !pwrite && paddr == 8'h30
      |=> prdata == {24'h0, $past(drive_reg[4])})
    else $error("group read not lowest port");

  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !tb_tick |=> $stable(pwm_cnt_reg))
    else $error("PWM counter moved without a tick");

endmodule // ppc_top

// >>> ppc_pkg.sv
package ppc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS  = 10;
  localparam int CODE_W     = 8;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int IDX_W      = 6;
  localparam int PWM_CNT_W  = 8;

  // ---------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PORT_DRIVE_0   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_PORT_DRIVE_9   = 6'h09;
  localparam logic [IDX_W-1:0] IDX_GROUP_ALL      = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_GROUP_0_3      = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_GROUP_4_7      = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_GROUP_8_9      = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_PIN_LEVELS_LOW  = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_PIN_LEVELS_HIGH = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_PWM_CONFIG     = 6'h10;

  // ---------------------------------------------------------------
  // Drive codes
  // ---------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_LOGIC_LOW   = 8'h00;
  localparam logic [CODE_W-1:0] CODE_LOGIC_INPUT = 8'h01;
  localparam logic [CODE_W-1:0] CODE_SINK_STATIC = 8'h02;
  localparam logic [CODE_W-1:0] CODE_PWM_FIRST   = 8'h03;
  localparam logic [CODE_W-1:0] CODE_PWM_LAST    = 8'hfe;
  localparam logic [CODE_W-1:0] CODE_HIGH_Z      = 8'hff;

  // ---------------------------------------------------------------
  // Configuration fields and reset values
  // ---------------------------------------------------------------
  localparam int CFG_CLK_SEL_BIT = 7;
  localparam int CFG_RUN_BIT     = 0;
  localparam logic [CODE_W-1:0] PORT_DRIVE_RESET = 8'hff;
  localparam logic              CFG_RUN_RESET    = 1'b1;

endpackage : ppc_pkg

// >>> ppc_pin_model.sv
module ppc_pin_model
  import ppc_pkg::*;
(
  input  wire logic [ppc_pkg::NUM_PORTS-1:0] ext_level,
  input  wire logic [ppc_pkg::NUM_PORTS-1:0] pin_oe,
  input  wire logic [ppc_pkg::NUM_PORTS-1:0] sink_en,
  output logic      [ppc_pkg::NUM_PORTS-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin pulled low while driven low or sinking LED current
  assign pin_level = ext_level & ~(pin_oe | sink_en);
endmodule // ppc_pin_model

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ppc_pkg::*;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 ce = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 osc = 1'b0;
  logic                 ext_clk = 1'b0;
  logic [NUM_PORTS-1:0] ext_lvl = '0;
  logic [NUM_PORTS-1:0] pin_in, pin_out, pin_oe, sink, gib;
  logic [7:0]           code_m [NUM_PORTS];
  int                   failures = 0;
  int                   comparisons = 0;
  int                   cyc = 0;
  // ---------------------------------------------------------
  // Clocks and instances
  // ---------------------------------------------------------
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc     <= cyc + 1;
    osc     <= (cyc % 16) < 8;
    ext_clk <= (cyc % 24) < 12;
  end
  ppc_top i_ppc_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_osc_in(osc),
    .serial_out_or_pwm_clock_pin_in(ext_clk), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe(pin_oe),
    .port_sink_en(sink), .general_input_buffer_en(gib));
  ppc_pin_model i_ppc_pin_model (.ext_level(ext_lvl), .pin_oe(pin_oe),
    .sink_en(sink), .pin_level(pin_in));
  // ---------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
  endtask
  function automatic logic [7:0] pick(input int unsigned r);
    case (r % 5)
      0: return 8'h00;
      1: return 8'h01;
      2: return 8'h02;
      3: return 8'hff;
      default: return 8'(3 + (r % 252));
    endcase
  endfunction
  task automatic grp(input int idx, lo, hi, input logic [7:0] c);
    wr(8'(4 * idx), {24'h0, c});
    for (int i = lo; i <= hi; i++) code_m[i] = c;
  endtask
  task automatic check_pins();
    logic [NUM_PORTS-1:0] oe_e, gib_e, lvl, st, sk_e;
    repeat (6) @(posedge pclk);
    for (int i = 0; i < NUM_PORTS; i++) begin
      oe_e[i]  = code_m[i] == 8'h00;
      gib_e[i] = code_m[i] <= 8'h01;
      lvl[i]   = (code_m[i] == 8'h01) & ext_lvl[i];
      st[i]    = code_m[i] < 8'h03 || code_m[i] == 8'hff;
      sk_e[i]  = code_m[i] == 8'h02;
    end
    chk(32'(pin_oe), 32'(oe_e), "drive low");
    chk(32'(pin_out), 32'h0, "open drain low");
    chk(32'(gib), 32'(gib_e), "input buffer");
    chk(32'(sink & st), 32'(sk_e), "static sink");
    rd_chk(8'h38, {24'h0, lvl[7:0]});
    rd_chk(8'h3c, {30'h0, lvl[9:8]});
  endtask
  task automatic complete_run();
    $display("Counts: %0d failures, %0d comparisons", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ---------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------
  initial begin
    #1_000_000;
    failures++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  c;
    int          per, n;
    void'($urandom(32'h3b76));
    for (int i = 0; i < NUM_PORTS; i++) code_m[i] = 8'hff;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h40, 32'h1);
    for (int it = 0; it < 24; it++) begin
      for (int i = 0; i < NUM_PORTS; i++)
        rd_chk(8'(4 * i), {24'h0, code_m[i]});
      rd_chk(8'h28, {24'h0, code_m[0]});
      rd_chk(8'h2c, {24'h0, code_m[0]});
      rd_chk(8'h30, {24'h0, code_m[4]});
      rd_chk(8'h34, {24'h0, code_m[8]});
      check_pins();
      c = pick($urandom);
      case ($urandom % 5)
        0: grp(10, 0, 9, c);
        1: grp(11, 0, 3, c);
        2: grp(12, 4, 7, c);
        3: grp(13, 8, 9, c);
        default: for (int i = 0; i < NUM_PORTS; i++) grp(i, i, i, pick($urandom));
      endcase
      wr(8'h38, $urandom);
      wr(8'h3c, $urandom);
      ext_lvl <= NUM_PORTS'($urandom);
    end
    ce <= 1'b0;
    wr(8'h00, {24'h0, ~code_m[0]});
    ce <= 1'b1;
    rd_chk(8'h00, {24'h0, code_m[0]});
    apb(1'b0, 8'h44, 32'h0, r, e);
    chk(r, 32'h0, "unmapped data");
    chk(32'(e), 32'h1, "unmapped error");
    apb(1'b1, 8'h01, 32'hff, r, e);
    chk(32'(e), 32'h1, "misaligned");
    grp(10, 0, 9, 8'h02);
    wr(8'h40, 32'h0);
    grp(11, 0, 3, 8'h00);
    grp(12, 4, 7, 8'h80);
    repeat (300) @(posedge pclk);
    chk(32'(sink), 32'h0, "sink in shutdown");
    chk(32'(pin_oe), 32'h00f, "low in shutdown");
    wr(8'h40, 32'h1);
    for (int s = 0; s < 3; s++) begin
      if (s > 0) wr(8'h40, (s == 2) ? 32'h81 : 32'h01);
      c = (s == 0) ? 8'h03 : (s == 2) ? 8'hfe : 8'(3 + $urandom % 252);
      per = (s == 2) ? 24 : 16;
      grp(10, 0, 9, c);
      repeat (100) @(posedge pclk);
      n = 0;
      repeat (256 * per) begin
        @(posedge pclk);
        n += int'(sink[5]);
      end
      chk(32'(n), 32'(c) * 32'(per), "duty");
    end
    complete_run();
  end
endmodule // tb_top
